// *** cosb_pkg.sv ***
package cosb_pkg;
  localparam int NUM_OUT_DEF = 20;
  localparam int AW = 8;
  // byte offsets of the register words
  localparam logic [7:0] OFS_OUT_EN = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SB_CTRL = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  // control word fields
  localparam int CTRL_EDGE_SRC = 0;
  localparam int CTRL_EDGE_VAL = 1;
  // status word fields
  localparam int ST_LOST = 0;
  localparam int ST_STARTED = 1;
  localparam int ST_PWRDN = 2;
  localparam int ST_SBMODE = 3;
  localparam int ST_EDGE = 4;
  localparam int ST_ADDR_LSB = 8;
  // interrupt event bits
  localparam int EV_LOST = 0;
  localparam int EV_REGAIN = 1;
  localparam int EV_LOAD = 2;
  localparam int EV_PWRDN = 3;
  localparam int NUM_EV = 4;
  // shared pin positions in the enable pin group
  localparam int SI_IDX = 5;
  localparam int SCK_IDX = 6;
  localparam int SHLD_IDX = 10;
  // tri-level strap codes
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  localparam logic [6:0] ADDR_BASE_DEF = 7'h68;
  localparam logic [3:0] TRI_RADIX = 4'h3;
  // reference clock loss detection time
  localparam int MCLK_PERIOD_PS = 5000;
  localparam int LOSS_TIME_NS = 2000;
  localparam int LOSS_CYC_DEF = (LOSS_TIME_NS * 1000) / MCLK_PERIOD_PS;

  typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_PDOWN} cosb_pwr_t;

  // invalid code counts as the middle level
  function automatic logic [3:0] tri_decode(input logic [1:0] code);
    unique case (code)
      TRI_LOW: tri_decode = 4'h0;
      TRI_HIGH: tri_decode = 4'h2;
      default: tri_decode = 4'h1;
    endcase
  endfunction
endpackage

// *** cosb_top.sv ***
// How it works
// - enable pins low run output, high stop
// - select strap picks enable or side-band pins
// - bus bits and unshared pins stay active
// - shift clock rise shifts data-in bit
// - shared data pin is serial input only
// - shift/load high shifts, low holds
// - shift/load fall copies into control register
// - register end drives serial data out pin
// - lost reference pulls open-drain flag low
// - lost reference parks all outputs
// - first power-good high latches straps, starts
// - later low powers down, high wakes
// - two tri-level straps give nine addresses
// - edge rate from pin or control bit
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module cosb_top #(
  parameter int NUM_OUT = cosb_pkg::NUM_OUT_DEF,
  parameter int LOSS_CYC = cosb_pkg::LOSS_CYC_DEF,
  parameter logic [6:0] ADDR_BASE = cosb_pkg::ADDR_BASE_DEF
) (
  input wire logic MCLK, // system clock
  input wire logic RESETN, // async reset, low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [cosb_pkg::AW-1:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped
  input wire logic [NUM_OUT-1:0] OUTPUT_ENABLE_N_PIN, // enable pins, low
  input wire logic SIDEBAND_SELECT_STRAP, // side-band select strap
  input wire logic REF_CLOCK_IN, // reference clock
  input wire logic POWER_GOOD_DOWN_N, // power good, low powers down
  input wire logic [1:0] ADDR_STRAP_0, // tri-level strap code
  input wire logic [1:0] ADDR_STRAP_1, // tri-level strap code
  input wire logic EDGE_RATE_PIN, // edge rate pin
  output logic [NUM_OUT-1:0] CLOCK_RUN, // output runs when high
  output logic EDGE_RATE_FAST, // chosen edge rate
  output logic SERIAL_OUT_PIN, // side-band data out
  output logic INPUT_LOST_N_O, // loss flag drive value
  output logic INPUT_LOST_N_OE, // loss flag pulls low
  output logic [6:0] MGMT_ADDR, // decoded target address
  output logic IRQ // interrupt, high
);
  import cosb_pkg::*;

  localparam int CW = $clog2(LOSS_CYC + 1);
  localparam int SW = NUM_OUT + 8;

  initial begin
    if (NUM_OUT <= SHLD_IDX || NUM_OUT > 32 || LOSS_CYC < 2) begin
      $error("cosb_top: unsupported parameter values");
    end
  end

  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [2:0] edge_del;
  logic [NUM_OUT-1:0] oe_n;
  logic ref_s, pg_s, strap_s, edge_pin_s;
  logic [1:0] a0_s, a1_s;
  logic ref_rise, sck_rise, shld_fall;
  logic serial_in_pin, shift_load_n_pin;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {OUTPUT_ENABLE_N_PIN, SIDEBAND_SELECT_STRAP, REF_CLOCK_IN,
                POWER_GOOD_DOWN_N, ADDR_STRAP_0, ADDR_STRAP_1, EDGE_RATE_PIN};
      sync2 <= sync1;
    end
  end

  assign {oe_n, strap_s, ref_s, pg_s, a0_s, a1_s, edge_pin_s} = sync2;
  assign serial_in_pin = oe_n[SI_IDX];
  assign shift_load_n_pin = oe_n[SHLD_IDX];

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      edge_del <= '0;
    end else begin
      edge_del <= {ref_s, oe_n[SCK_IDX], shift_load_n_pin};
    end
  end

  assign ref_rise = ref_s && !edge_del[2];
  assign sck_rise = oe_n[SCK_IDX] && !edge_del[1];
  assign shld_fall = !shift_load_n_pin && edge_del[0];

  // power sequencing and strap capture
  cosb_pwr_t st;
  logic mode_sb;
  logic started;
  logic pwrdn;
  logic ev_pwrdn;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= ST_WAIT;
    end else begin
      unique case (st)
        ST_WAIT: if (pg_s) st <= ST_RUN;
        ST_RUN: if (!pg_s) st <= ST_PDOWN;
        ST_PDOWN: if (pg_s) st <= ST_RUN;
      endcase
    end
  end

  assign started = (st != ST_WAIT);
  assign pwrdn = (st == ST_PDOWN);
  assign ev_pwrdn = (st == ST_RUN) && !pg_s;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_sb <= 1'b0;
      MGMT_ADDR <= ADDR_BASE;
    end else if (st == ST_WAIT && pg_s) begin
      mode_sb <= strap_s;
      MGMT_ADDR <= ADDR_BASE + 7'(tri_decode(a1_s) * TRI_RADIX)
                   + 7'(tri_decode(a0_s));
    end
  end

  // reference clock loss watchdog
  logic [CW-1:0] quiet_cnt;
  logic lost;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      quiet_cnt <= '0;
      lost <= 1'b0;
    end else if (ref_rise) begin
      quiet_cnt <= '0;
      lost <= 1'b0;
    end else if (quiet_cnt == CW'(LOSS_CYC - 1)) begin
      lost <= 1'b1;
    end else begin
      quiet_cnt <= quiet_cnt + 1'b1;
    end
  end

  assign INPUT_LOST_N_O = 1'b0;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      INPUT_LOST_N_OE <= 1'b0;
    end else begin
      INPUT_LOST_N_OE <= lost;
    end
  end

  // side-band shift and output control registers, active low bits
  logic [NUM_OUT-1:0] sreg;
  logic [NUM_OUT-1:0] sb_ctrl;
  logic sb_live;
  logic sb_shift;
  logic sb_load;

  assign sb_live = mode_sb && started;
  assign sb_shift = sb_live && sck_rise && shift_load_n_pin;
  assign sb_load = sb_live && shld_fall;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sreg <= '0;
    end else if (sb_shift) begin
      sreg <= {sreg[NUM_OUT-2:0], serial_in_pin};
    end
  end

  assign SERIAL_OUT_PIN = sreg[NUM_OUT-1];

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sb_ctrl <= '0;
    end else if (sb_load) begin
      sb_ctrl <= sreg;
    end
  end

  // register file over apb
  logic [NUM_OUT-1:0] mgmt_en;
  logic [1:0] ctrl;
  logic [NUM_EV-1:0] int_st;
  logic [NUM_EV-1:0] int_mask;
  logic [NUM_EV-1:0] ev_set;
  logic lost_d;
  logic wr_acc;
  logic [31:0] next_rdata;

  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = (a == OFS_OUT_EN) || (a == OFS_CTRL) ||
                (a == OFS_STATUS) || (a == OFS_SB_CTRL) ||
                (a == OFS_INT_STATUS) || (a == OFS_INT_MASK);
  endfunction

  assign wr_acc = PSEL && PENABLE && PREADY && PWRITE && is_mapped(PADDR);

  always_comb begin
    next_rdata = '0;
    unique case (PADDR)
      OFS_OUT_EN: next_rdata[NUM_OUT-1:0] = mgmt_en;
      OFS_CTRL: next_rdata[1:0] = ctrl;
      OFS_STATUS: begin
        next_rdata[ST_LOST] = lost;
        next_rdata[ST_STARTED] = started;
        next_rdata[ST_PWRDN] = pwrdn;
        next_rdata[ST_SBMODE] = mode_sb;
        next_rdata[ST_EDGE] = EDGE_RATE_FAST;
        next_rdata[ST_ADDR_LSB +: 7] = MGMT_ADDR;
      end
      OFS_SB_CTRL: next_rdata[NUM_OUT-1:0] = sb_ctrl;
      OFS_INT_STATUS: next_rdata[NUM_EV-1:0] = int_st;
      OFS_INT_MASK: next_rdata[NUM_EV-1:0] = int_mask;
      default: next_rdata = '0;
    endcase
  end

  // answer in the first access cycle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : next_rdata;
        PSLVERR <= !is_mapped(PADDR);
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mgmt_en <= '1;
      ctrl <= '0;
      int_mask <= '0;
    end else if (wr_acc) begin
      if (PADDR == OFS_OUT_EN) mgmt_en <= PWDATA[NUM_OUT-1:0];
      if (PADDR == OFS_CTRL) ctrl <= PWDATA[1:0];
      if (PADDR == OFS_INT_MASK) int_mask <= PWDATA[NUM_EV-1:0];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      lost_d <= 1'b0;
    end else begin
      lost_d <= lost;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[EV_LOST] = lost && !lost_d;
    ev_set[EV_REGAIN] = !lost && lost_d;
    ev_set[EV_LOAD] = sb_load;
    ev_set[EV_PWRDN] = ev_pwrdn;
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      int_st <= '0;
    end else if (wr_acc && PADDR == OFS_INT_STATUS) begin
      int_st <= (int_st & ~PWDATA[NUM_EV-1:0]) | ev_set;
    end else begin
      int_st <= int_st | ev_set;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_st & int_mask);
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      EDGE_RATE_FAST <= 1'b0;
    end else begin
      EDGE_RATE_FAST <= ctrl[CTRL_EDGE_SRC] ? ctrl[CTRL_EDGE_VAL]
                                            : edge_pin_s;
    end
  end

  // output gating
  logic run_ok;
  assign run_ok = started && !pwrdn && !lost;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    localparam bit SH = (i == SI_IDX) || (i == SCK_IDX) || (i == SHLD_IDX);
    logic pin_ok;
    assign pin_ok = mode_sb ? ((SH || !oe_n[i]) && !sb_ctrl[i])
                            : !oe_n[i];
    always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
        CLOCK_RUN[i] <= 1'b0;
      end else begin
        CLOCK_RUN[i] <= run_ok && pin_ok && mgmt_en[i];
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  sequence s_shift_req;
    sb_live && sck_rise && shift_load_n_pin;
  endsequence

  sequence s_load_req;
    sb_live && shld_fall;
  endsequence

  chk_park_on_loss: assert property (lost |=> CLOCK_RUN == '0)
    else $error("outputs run while reference lost");
  chk_loss_flag: assert property ($rose(lost) |=> INPUT_LOST_N_OE
    && !INPUT_LOST_N_O)
    else $error("loss flag not pulled low");
  chk_shift_step: assert property (s_shift_req |=>
    sreg == {$past(sreg[NUM_OUT-2:0]), $past(serial_in_pin)})
    else $error("shift register did not take data bit");
  chk_hold_shift: assert property (sb_live && !shift_load_n_pin
    |=> $stable(sreg))
    else $error("shift register moved while held");
  chk_load_copy: assert property (s_load_req |=>
    sb_ctrl == $past(sreg))
    else $error("control register not loaded");
  chk_chain_out: assert property (s_shift_req |=>
    SERIAL_OUT_PIN == $past(sreg[NUM_OUT-2]))
    else $error("serial out not next bit");
  chk_pwrdn_stop: assert property ((st == ST_PDOWN) [*2]
    |-> CLOCK_RUN == '0)
    else $error("outputs run in power down");
  chk_strap_addr: assert property ($rose(started) |-> MGMT_ADDR ==
    ADDR_BASE + 7'(tri_decode($past(a1_s)) * TRI_RADIX)
    + 7'(tri_decode($past(a0_s))))
    else $error("address not decoded from straps");
  chk_bus_gate: assert property (!mgmt_en[0] |=> !CLOCK_RUN[0])
    else $error("output runs with bus enable off");
  chk_pin_gate: assert property (!mode_sb && oe_n[0]
    |=> !CLOCK_RUN[0])
    else $error("output runs with pin high");
endmodule

// *** cosb_board.sv ***
`timescale 1ns/1ps
module cosb_board (
  input wire logic lclk, // link clock, 64 ns period
  input wire logic go, // rising edge starts one frame
  input wire logic no_load, // keep shift/load low for the whole frame
  input wire logic [19:0] word, // enable word, bit 19 goes out first
  output logic sck, // shift clock, still between frames
  output logic sdi, // serial data
  output logic shld, // shift/load
  output logic busy // frame in progress
);
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    shld = 1'b0;
    busy = 1'b0;
  end

  // data changes half a link period before each shift clock rise
  always @(posedge go) begin
    busy = 1'b1;
    @(negedge lclk);
    shld = ~no_load;
    for (int i = 19; i >= 0; i--) begin
      sdi = word[i];
      @(posedge lclk);
      sck = 1'b1;
      @(negedge lclk);
      sck = 1'b0;
    end
    shld = 1'b0;
    @(negedge lclk);
    // released data line falls to the pin's pull-down level
    sdi = 1'b0;
    busy = 1'b0;
  end
endmodule

// *** cosb_top_test.sv ***
`timescale 1ns/1ps
module cosb_top_test;
  import cosb_pkg::*;
  localparam int LOSS = 16;
  localparam int LIMIT = 20000;
  localparam logic [19:0] W1 = 20'hA5C3E;
  localparam logic [19:0] W2 = 20'h3C5A1;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, EDGE_RATE_FAST, SERIAL_OUT_PIN, IRQ;
  logic INPUT_LOST_N_O, INPUT_LOST_N_OE;
  logic [6:0] MGMT_ADDR;
  logic [19:0] CLOCK_RUN;
  logic [19:0] OUTPUT_ENABLE_N_PIN;
  logic [19:0] pins_q = 20'h00000;
  logic SIDEBAND_SELECT_STRAP = 1'b0;
  logic REF_CLOCK_IN = 1'b0;
  logic POWER_GOOD_DOWN_N = 1'b0;
  logic [1:0] ADDR_STRAP_0 = 2'h0;
  logic [1:0] ADDR_STRAP_1 = 2'h0;
  logic EDGE_RATE_PIN = 1'b0;
  logic lclk = 1'b0;
  logic ref_on = 1'b1;
  logic go = 1'b0;
  logic no_load = 1'b0;
  logic sb_on = 1'b0;
  logic [19:0] word = 20'h00000;
  logic sck, sdi, shld, busy, lost_n;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 MCLK = ~MCLK;
  always #32 lclk = ~lclk;
  always #32 if (ref_on) REF_CLOCK_IN = ~REF_CLOCK_IN;
  // open-drain flag with external pull-up
  assign lost_n = INPUT_LOST_N_OE ? INPUT_LOST_N_O : 1'b1;

  always_comb begin
    OUTPUT_ENABLE_N_PIN = pins_q;
    if (sb_on) begin
      OUTPUT_ENABLE_N_PIN[SI_IDX] = sdi;
      OUTPUT_ENABLE_N_PIN[SCK_IDX] = sck;
      OUTPUT_ENABLE_N_PIN[SHLD_IDX] = shld;
    end
  end

  cosb_top #(.LOSS_CYC(LOSS)) uut (.MCLK(MCLK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OUTPUT_ENABLE_N_PIN(OUTPUT_ENABLE_N_PIN),
    .SIDEBAND_SELECT_STRAP(SIDEBAND_SELECT_STRAP),
    .REF_CLOCK_IN(REF_CLOCK_IN), .POWER_GOOD_DOWN_N(POWER_GOOD_DOWN_N),
    .ADDR_STRAP_0(ADDR_STRAP_0), .ADDR_STRAP_1(ADDR_STRAP_1),
    .EDGE_RATE_PIN(EDGE_RATE_PIN), .CLOCK_RUN(CLOCK_RUN),
    .EDGE_RATE_FAST(EDGE_RATE_FAST), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
    .INPUT_LOST_N_O(INPUT_LOST_N_O), .INPUT_LOST_N_OE(INPUT_LOST_N_OE),
    .MGMT_ADDR(MGMT_ADDR), .IRQ(IRQ));

  cosb_board board (.lclk(lclk), .go(go), .no_load(no_load), .word(word),
    .sck(sck), .sdi(sdi), .shld(shld), .busy(busy));

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge MCLK) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("Error at %0t: run timed out", $time);
      close_out();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // PREADY seen high ends this wait; if it never comes, the bench timeout ends it
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    cmp(32'(e), 32'(ee), "write error flag");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, x, "read data");
    cmp(32'(e), 32'(ee), "read error flag");
  endtask

  task automatic restart(input logic sb, input int c0, input int c1);
    RESETN <= 1'b0;
    POWER_GOOD_DOWN_N <= 1'b0;
    SIDEBAND_SELECT_STRAP <= sb;
    ADDR_STRAP_0 <= 2'(c0);
    ADDR_STRAP_1 <= 2'(c1);
    sb_on <= sb;
    wait_clk(10);
    RESETN <= 1'b1;
    wait_clk(8);
    cmp(32'(CLOCK_RUN), 32'h0, "run before start");
    POWER_GOOD_DOWN_N <= 1'b1;
    wait_clk(8);
  endtask

  // cur is the loaded side-band word while this frame shifts
  task automatic frame(input logic [19:0] w, input logic nl,
                       input logic [19:0] cur);
    word <= w;
    no_load <= nl;
    go <= 1'b1;
    while (busy !== 1'b1) @(posedge MCLK);
    go <= 1'b0;
    wait_clk(150);
    cmp(32'(CLOCK_RUN & 20'h00460), 32'(~cur & 20'h00460), "mid");
    while (busy === 1'b1) @(posedge MCLK);
    wait_clk(8);
  endtask

  initial begin
    for (int j = 0; j < 9; j++) begin
      restart(1'b0, j % 3, j / 3);
      cmp(32'(MGMT_ADDR), 32'(ADDR_BASE_DEF) + 32'(3 * (j / 3) + j % 3),
          "address");
    end
    ADDR_STRAP_0 <= TRI_LOW;
    wait_clk(6);
    cmp(32'(MGMT_ADDR), 32'h70, "address latch");
    rd(OFS_STATUS, (32'h70 << ST_ADDR_LSB) | (1 << ST_STARTED), 1'b0);
    rd(OFS_OUT_EN, 32'h000FFFFF, 1'b0);
    rd(OFS_CTRL, 32'h0, 1'b0);
    rd(OFS_SB_CTRL, 32'h0, 1'b0);
    rd(OFS_INT_MASK, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    wr(8'h18, 32'hFFFFFFFF, 1'b1);
    $display("test registers done");
    pins_q <= 20'h0F0F0;
    wait_clk(6);
    cmp(32'(CLOCK_RUN), 32'hF0F0F, "pin enables");
    wr(OFS_OUT_EN, 32'h000FFFF0, 1'b0);
    wait_clk(2);
    cmp(32'(CLOCK_RUN), 32'hF0F00, "bus enables");
    for (int k = 0; k < 8; k++) begin
      EDGE_RATE_PIN <= k[2];
      wr(OFS_CTRL, 32'(k[1:0]), 1'b0);
      wait_clk(5);
      cmp(32'(EDGE_RATE_FAST), 32'(k[0] ? k[1] : k[2]), "edge");
    end
    POWER_GOOD_DOWN_N <= 1'b0;
    wait_clk(6);
    cmp(32'(CLOCK_RUN), 32'h0, "power down");
    POWER_GOOD_DOWN_N <= 1'b1;
    wait_clk(6);
    cmp(32'(CLOCK_RUN), 32'hF0F00, "wake");
    ref_on <= 1'b0;
    wait_clk(LOSS + 10);
    cmp(32'(lost_n), 32'h0, "loss flag");
    cmp(32'(CLOCK_RUN), 32'h0, "parked");
    ref_on <= 1'b1;
    wait_clk(20);
    cmp(32'(lost_n), 32'h1, "loss flag release");
    cmp(32'(CLOCK_RUN), 32'hF0F00, "unparked");
    $display("test pins done");
    rd(OFS_INT_STATUS, 32'hB, 1'b0);
    cmp(32'(IRQ), 32'h0, "irq masked");
    wr(OFS_INT_MASK, 32'h1, 1'b0);
    wait_clk(2);
    cmp(32'(IRQ), 32'h1, "irq on");
    wr(OFS_INT_STATUS, 32'h1, 1'b0);
    wait_clk(2);
    cmp(32'(IRQ), 32'h0, "irq cleared");
    rd(OFS_INT_STATUS, 32'hA, 1'b0);
    wr(OFS_INT_MASK, 32'hF, 1'b0);
    wait_clk(2);
    cmp(32'(IRQ), 32'h1, "irq other");
    wr(OFS_INT_STATUS, 32'hF, 1'b0);
    wait_clk(2);
    cmp(32'(IRQ), 32'h0, "irq all cleared");
    $display("test interrupts done");
    // strap code 3 counts as the middle level
    restart(1'b1, 3, 0);
    pins_q <= 20'h00008;
    cmp(32'(MGMT_ADDR), 32'(ADDR_BASE_DEF) + 32'h1, "mid code");
    rd(OFS_STATUS, (32'h69 << ST_ADDR_LSB) | (1 << ST_STARTED) |
       (1 << ST_SBMODE) | (1 << ST_EDGE), 1'b0);
    wait_clk(4);
    cmp(32'(CLOCK_RUN), 32'hFFFF7, "side-band idle");
    frame(W1, 1'b0, 20'h0);
    cmp(32'(SERIAL_OUT_PIN), 32'(W1[19]), "serial out");
    rd(OFS_SB_CTRL, 32'(W1), 1'b0);
    cmp(32'(CLOCK_RUN), 32'(~W1 & 20'hFFFF7), "loaded");
    rd(OFS_INT_STATUS, 32'(1 << EV_LOAD), 1'b0);
    frame(W2, 1'b1, W1);
    cmp(32'(SERIAL_OUT_PIN), 32'(W1[19]), "no shift");
    rd(OFS_SB_CTRL, 32'(W1), 1'b0);
    frame(W2, 1'b0, W1);
    cmp(32'(SERIAL_OUT_PIN), 32'(W2[19]), "serial out");
    rd(OFS_SB_CTRL, 32'(W2), 1'b0);
    wr(OFS_OUT_EN, 32'h000FFFFE, 1'b0);
    wait_clk(2);
    cmp(32'(CLOCK_RUN), 32'(~W2 & 20'hFFFF6), "bus bit");
    $display("test side-band done");
    close_out();
  end
endmodule
